// ===== rtl/opmode_pkg.sv
// Constants for operating mode selection and address decode
package opmode_pkg;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_SINGLE    = 6'h01,
        MODE_BOOT_SCI  = 6'h02,
        MODE_BOOT_USB  = 6'h04,
        MODE_USER_BOOT = 6'h08,
        MODE_EXT_NOROM = 6'h10,
        MODE_EXT_ROM   = 6'h20
    } mode_type;

    // Write protect control bit positions
    localparam int CLK_UNLOCK_BIT  = 0;
    localparam int MODE_UNLOCK_BIT = 1;

    // System control zero reset values
    localparam logic ROM_ENABLE_RST = 1'b1;
    localparam logic EXT_BUS_RST    = 1'b0;

    // Address map
    localparam logic [31:0] RAM_BASE      = 32'h0000_0000;
    localparam logic [31:0] RAM_LAST      = 32'h0007_FFFF;
    localparam logic [31:0] PERIA_BASE    = 32'h0008_0000;
    localparam logic [31:0] PERIA_LAST    = 32'h000A_3FFF;
    localparam logic [31:0] PERIB_BASE    = 32'h000A_6000;
    localparam logic [31:0] PERIB_LAST    = 32'h000F_FFFF;
    localparam logic [31:0] FLASHREG_BASE = 32'h007F_E000;
    localparam logic [31:0] FLASHREG_LAST = 32'h007F_FFFF;
    localparam logic [31:0] EXTLO_BASE    = 32'h0100_0000;
    localparam logic [31:0] EXTLO_LAST    = 32'h0FFF_FFFF;
    localparam logic [31:0] SDRAM_BASE    = 32'h0800_0000;
    localparam logic [31:0] EXTHI_BASE    = 32'hFF00_0000;
    localparam logic [31:0] EXTHI_LAST    = 32'hFFFF_FFFF;
    localparam logic [31:0] ROM_BASE      = 32'hFFC0_0000;

    // Chip-select regions: 16 MB each, eight of them
    localparam int CS_COUNT   = 8;
    localparam int CS_SHIFT   = 24;

    // Clock sources
    localparam logic [1:0] CLKSRC_LOW_OSC  = 2'h0;
    localparam logic [1:0] CLKSRC_HIGH_OSC = 2'h1;
    localparam logic [1:0] CLKSRC_MAIN_OSC = 2'h2;
    localparam logic [1:0] CLKSRC_PLL      = 2'h3;

endpackage : opmode_pkg

// ===== rtl/region_decode.sv
// Combinational address decoder for the device address map
`timescale 1ns/1ps
`default_nettype none
module region_decode
    import opmode_pkg::*;
(
    // Address and mode
    input  wire logic [31:0] addr,
    input  wire logic        romOn,
    input  wire logic        extOn,
    // Region selects
    output logic             selRam,
    output logic             selPeri,
    output logic             selFlashReg,
    output logic             selRom,
    output logic [7:0]       selCs,
    output logic             selSdram
);
    function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : inRange

    logic hiSpace;
    logic loExt;

    always_comb begin
        hiSpace     = inRange(addr, EXTHI_BASE, EXTHI_LAST);
        loExt       = inRange(addr, EXTLO_BASE, EXTLO_LAST);
        selRam      = inRange(addr, RAM_BASE, RAM_LAST);
        selPeri     = inRange(addr, PERIA_BASE, PERIA_LAST)
                      || inRange(addr, PERIB_BASE, PERIB_LAST);
        selFlashReg = inRange(addr, FLASHREG_BASE, FLASHREG_LAST);
        selRom      = romOn && inRange(addr, ROM_BASE, EXTHI_LAST);
        selCs       = 8'h00;
        selSdram    = 1'b0;
        if (extOn) begin
            if (loExt && addr >= SDRAM_BASE) begin
                selSdram = 1'b1;
            end else if (loExt) begin
                // Region seven sits lowest; region zero lives in the top space
                selCs[3'(4'h8 - {1'b0, addr[26:24]})] = 1'b1;
            end else if (hiSpace && !romOn) begin
                // region zero only when ROM off
                selCs[0] = 1'b1;
            end
        end
    end
endmodule : region_decode
`default_nettype wire

// ===== rtl/opmode_ctrl.sv
// Operating mode selection, write protection and address decode
`timescale 1ns/1ps
`default_nettype none
module opmode_ctrl
    import opmode_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Mode pins
    input  wire logic        modeSelectPin,
    input  wire logic        userBootPin,
    // Write protect control
    input  wire logic        protWrite,
    input  wire logic [1:0]  protData,
    // System control zero write
    input  wire logic        sysWrite,
    input  wire logic        romEnableIn,
    input  wire logic        extBusEnableIn,
    // Clock control write
    input  wire logic        clkWrite,
    input  wire logic [1:0]  clkSrcIn,
    input  wire logic [3:0]  oscRunIn,
    // Address from bus masters
    input  wire logic [31:0] busAddr,
    // Status
    output logic [1:0]       writeProtectControl,
    output logic             onchipRomEnable,
    output logic             externalBusEnable,
    output mode_type         opMode,
    output logic             pinsModeSelect,
    output logic             pinsUserBoot,
    output logic [1:0]       clkSrc,
    output logic [3:0]       oscRun,
    // Region selects
    output logic             selRam,
    output logic             selPeri,
    output logic             selFlashReg,
    output logic             selRom,
    output logic [7:0]       selCs,
    output logic             selSdram
);
    typedef struct packed {
        logic       modeMeta;
        logic       bootMeta;
        logic       modeSync;
        logic       bootSync;
        logic       inReset;
        logic       modeCap;
        logic       bootCap;
        logic [1:0] prot;
        logic       romEn;
        logic       extEn;
        logic [1:0] clkSrc;
        logic [3:0] oscRun;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic      romOn;
    logic      extOn;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.modeMeta = modeSelectPin;
        st_nxt.bootMeta = userBootPin;
        st_nxt.modeSync = st_r.modeMeta;
        st_nxt.bootSync = st_r.bootMeta;
        st_nxt.inReset  = 1'b0;
        if (st_r.inReset) begin
            st_nxt.modeCap = st_r.modeSync;
            st_nxt.bootCap = st_r.bootSync;
        end
        if (protWrite) begin
            st_nxt.prot = protData;
        end
        if (sysWrite && st_r.prot[MODE_UNLOCK_BIT]) begin
            st_nxt.romEn = st_r.romEn && romEnableIn;
            st_nxt.extEn = extBusEnableIn;
        end
        if (clkWrite && (st_r.prot[CLK_UNLOCK_BIT] || st_r.prot[MODE_UNLOCK_BIT])) begin
            st_nxt.clkSrc = clkSrcIn;
            st_nxt.oscRun = oscRunIn;
        end
        if (!reset_n) begin
            st_nxt         = '0;
            st_nxt.inReset = 1'b1;
            st_nxt.modeMeta = modeSelectPin;
            st_nxt.bootMeta = userBootPin;
            st_nxt.modeSync = st_r.modeMeta;
            st_nxt.bootSync = st_r.bootMeta;
            st_nxt.romEn   = ROM_ENABLE_RST;
            st_nxt.extEn   = EXT_BUS_RST;
            st_nxt.clkSrc  = CLKSRC_LOW_OSC;
            st_nxt.oscRun  = 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    // Mode resolution
    always_comb begin
        if (st_r.extEn) begin
            opMode = st_r.romEn ? MODE_EXT_ROM : MODE_EXT_NOROM;
        end else if (st_r.modeCap) begin
            opMode = MODE_SINGLE;
        end else if (!st_r.bootCap) begin
            opMode = MODE_BOOT_SCI;
        end else begin
            opMode = MODE_USER_BOOT;
        end
    end

    assign extOn = st_r.extEn;
    assign romOn = st_r.romEn || !st_r.extEn;

    assign writeProtectControl = st_r.prot;
    assign onchipRomEnable     = st_r.romEn;
    assign externalBusEnable   = st_r.extEn;
    assign pinsModeSelect      = st_r.modeCap;
    assign pinsUserBoot        = st_r.bootCap;
    assign clkSrc              = st_r.clkSrc;
    assign oscRun              = st_r.oscRun;

    region_decode u_decode (
        .addr        (busAddr),
        .romOn       (romOn),
        .extOn       (extOn),
        .selRam      (selRam),
        .selPeri     (selPeri),
        .selFlashReg (selFlashReg),
        .selRom      (selRom),
        .selCs       (selCs),
        .selSdram    (selSdram)
    );

    a_reset_values: assert property (@(posedge mclk) !reset_n |=>
        onchipRomEnable && !externalBusEnable)
        else $error("reset values wrong");

    a_reset_clock: assert property (@(posedge mclk) !reset_n |=>
        clkSrc == CLKSRC_LOW_OSC && oscRun == 4'h1)
        else $error("clock not low-speed after reset");

    a_clock_locked: assert property (@(posedge mclk) disable iff (!reset_n)
        clkWrite && writeProtectControl == 2'h0 |=> $stable(clkSrc) && $stable(oscRun))
        else $error("locked clock write took effect");

    a_mode_locked: assert property (@(posedge mclk) disable iff (!reset_n)
        sysWrite && !writeProtectControl[MODE_UNLOCK_BIT] |=> $stable(externalBusEnable))
        else $error("locked mode write took effect");

    a_rom_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        !onchipRomEnable |=> !onchipRomEnable)
        else $error("ROM enable set again");

    sequence relSeq;
        !reset_n ##1 reset_n;
    endsequence

    a_pin_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |=> $stable(pinsModeSelect) && $stable(pinsUserBoot))
        else $error("captured pins changed");

    a_pin_single: assert property (@(posedge mclk)
        relSeq ##1 (pinsModeSelect && !externalBusEnable) |-> opMode == MODE_SINGLE)
        else $error("pin high not single-chip");

    a_single_noext: assert property (@(posedge mclk) disable iff (!reset_n)
        !externalBusEnable |-> selCs == 8'h00 && !selSdram)
        else $error("external select in single-chip");

    a_cs0_rom: assert property (@(posedge mclk) disable iff (!reset_n)
        opMode == MODE_EXT_ROM && busAddr >= EXTHI_BASE |-> !selCs[0])
        else $error("region zero active with ROM");

    sequence capSeq;
        relSeq ##1 !externalBusEnable;
    endsequence

    a_pin_capture: assert property (@(posedge mclk) relSeq |=>
        pinsModeSelect == $past(modeSelectPin, 3) && pinsUserBoot == $past(userBootPin, 3))
        else $error("pins not captured at release");

    a_pin_sci: assert property (@(posedge mclk)
        capSeq ##0 (!pinsModeSelect && !pinsUserBoot) |-> opMode == MODE_BOOT_SCI)
        else $error("low pins not serial boot");

    a_user_boot: assert property (@(posedge mclk)
        capSeq ##0 (!pinsModeSelect && pinsUserBoot) |-> opMode == MODE_USER_BOOT)
        else $error("user boot pins not user boot");

    a_ext_off_mode: assert property (@(posedge mclk) disable iff (!reset_n)
        !externalBusEnable |-> opMode inside {MODE_SINGLE, MODE_BOOT_SCI, MODE_USER_BOOT})
        else $error("external mode with bus off");

    a_osc_kept: assert property (@(posedge mclk) disable iff (!reset_n)
        !clkWrite |=> $stable(clkSrc) && $stable(oscRun))
        else $error("clock changed without a write");

    a_clock_open: assert property (@(posedge mclk) disable iff (!reset_n)
        clkWrite && writeProtectControl != 2'h0 |=> clkSrc == $past(clkSrcIn) && oscRun == $past(oscRunIn))
        else $error("unlocked clock write lost");

    a_mode_open: assert property (@(posedge mclk) disable iff (!reset_n)
        sysWrite && writeProtectControl[MODE_UNLOCK_BIT] |=> externalBusEnable == $past(extBusEnableIn))
        else $error("unlocked mode write lost");

    a_rom_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        sysWrite && writeProtectControl[MODE_UNLOCK_BIT] && !romEnableIn |=> !onchipRomEnable)
        else $error("ROM enable clear lost");

    a_norom_ext: assert property (@(posedge mclk) disable iff (!reset_n)
        opMode == MODE_EXT_NOROM && busAddr >= ROM_BASE |-> !selRom && selCs[0])
        else $error("ROM answered with ROM disabled");

    a_rom_ext: assert property (@(posedge mclk) disable iff (!reset_n)
        opMode == MODE_EXT_ROM && busAddr >= ROM_BASE |-> selRom)
        else $error("ROM missing with ROM enabled");

    a_ram_low: assert property (@(posedge mclk) disable iff (!reset_n)
        busAddr <= RAM_LAST |-> selRam && !selPeri && !selFlashReg)
        else $error("RAM not selected at bottom");

    a_peri_window: assert property (@(posedge mclk) disable iff (!reset_n)
        selPeri == (busAddr inside {[PERIA_BASE:PERIA_LAST], [PERIB_BASE:PERIB_LAST]}))
        else $error("peripheral select outside windows");

    a_flash_only: assert property (@(posedge mclk) disable iff (!reset_n)
        busAddr inside {[FLASHREG_BASE:FLASHREG_LAST]} |->
        selFlashReg && !selPeri && !selRam && !selRom && selCs == 8'h00 && !selSdram)
        else $error("flash window not exclusive");

    a_ext_ranges: assert property (@(posedge mclk) disable iff (!reset_n)
        (selCs != 8'h00 || selSdram) |->
        busAddr inside {[EXTLO_BASE:EXTLO_LAST], [EXTHI_BASE:EXTHI_LAST]})
        else $error("external select outside ranges");

    a_cs_onehot: assert property (@(posedge mclk) disable iff (!reset_n)
        $onehot0({selCs, selSdram}))
        else $error("several external selects");

    a_cs_first: assert property (@(posedge mclk) disable iff (!reset_n)
        externalBusEnable && busAddr[31:24] == 8'h01 |-> selCs == 8'h80)
        else $error("lowest region not seven");

    a_cs_last: assert property (@(posedge mclk) disable iff (!reset_n)
        externalBusEnable && busAddr[31:24] == 8'h07 |-> selCs == 8'h02)
        else $error("top low region not one");

    a_sdram_region: assert property (@(posedge mclk) disable iff (!reset_n)
        externalBusEnable && busAddr inside {[SDRAM_BASE:EXTLO_LAST]} |-> selSdram && selCs == 8'h00)
        else $error("SDRAM region not selected");
endmodule : opmode_ctrl
`default_nettype wire

// ===== testbench/addr_master.sv
// Bus master model that issues addresses to the decoder
`timescale 1ns/1ps
`default_nettype none
module addr_master (
    // Clock
    input  wire logic        mclk,
    // Request from bench
    input  wire logic        go,
    input  wire logic [31:0] target,
    // Address to decoder
    output var logic  [31:0] addr
);
    initial addr = 32'h0;
    // address held one cycle, then a changing pattern
    always @(posedge mclk) begin
        if (go) begin
            addr <= target;
        end else begin
            addr <= ~addr;
        end
    end
endmodule : addr_master
`default_nettype wire

// ===== testbench/operating_mode_address_decode_tb_top.sv
// Self-checking bench for mode selection and address decode
`timescale 1ns/1ps
`default_nettype none
module operating_mode_address_decode_tb_top;
    import opmode_pkg::*;
    logic        mclk, reset_n, modeSelectPin, userBootPin, go;
    logic        protWrite, sysWrite, clkWrite, romEnableIn, extBusEnableIn;
    logic [1:0]  protData, clkSrcIn, writeProtectControl, clkSrc;
    logic [3:0]  oscRunIn, oscRun;
    logic [31:0] busAddr, target;
    logic        onchipRomEnable, externalBusEnable, pinsModeSelect, pinsUserBoot;
    logic        selRam, selPeri, selFlashReg, selRom, selSdram;
    logic [7:0]  selCs;
    mode_type    opMode;
    int          failures, samples_checked;
    logic [31:0] at [15] = '{32'h0, 32'h7FFFF, 32'h80000, 32'hA3FFF, 32'hA4000,
        32'hA6000, 32'hFFFFF, 32'h7FE000, 32'h7FFFFF, 32'h1000000, 32'h7FFFFFF,
        32'h8000000, 32'hFFFFFFF, 32'hFF000000, 32'hFFFFFFFF};
    logic [12:0] ex [15] = '{13'h1000, 13'h1000, 13'h0800, 13'h0800, 13'h0000,
        13'h0800, 13'h0800, 13'h0400, 13'h0400, 13'h0100, 13'h0004, 13'h0001,
        13'h0001, 13'h0000, 13'h0200};

    opmode_ctrl u_dut (.mclk, .reset_n, .modeSelectPin, .userBootPin, .protWrite,
        .protData, .sysWrite, .romEnableIn, .extBusEnableIn, .clkWrite, .clkSrcIn,
        .oscRunIn, .busAddr, .writeProtectControl, .onchipRomEnable,
        .externalBusEnable, .opMode, .pinsModeSelect, .pinsUserBoot, .clkSrc,
        .oscRun, .selRam, .selPeri, .selFlashReg, .selRom, .selCs, .selSdram);
    addr_master u_master (.mclk, .go, .target, .addr(busAddr));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task rst(input logic ms, input logic ub);
        @(posedge mclk);
        reset_n <= 1'b0;
        modeSelectPin <= ms;
        userBootPin <= ub;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : rst

    // Kind 0 protect, 1 system control, 2 clock control
    task wr(input int k, input logic [5:0] d);
        @(posedge mclk);
        protWrite <= (k == 0);
        sysWrite <= (k == 1);
        clkWrite <= (k == 2);
        protData <= d[1:0];
        romEnableIn <= d[1];
        extBusEnableIn <= d[0];
        clkSrcIn <= d[5:4];
        oscRunIn <= d[3:0];
        @(posedge mclk);
        {protWrite, sysWrite, clkWrite} <= 3'h0;
        @(negedge mclk);
    endtask : wr

    task dec(input logic [31:0] a, input logic [12:0] e);
        @(posedge mclk);
        go <= 1'b1;
        target <= a;
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        chk({selRam, selPeri, selFlashReg, selRom, selCs, selSdram}, e);
    endtask : dec

    task t_reset;
        rst(1'b1, 1'b0);
        chk(onchipRomEnable, ROM_ENABLE_RST);
        chk(externalBusEnable, EXT_BUS_RST);
        chk(clkSrc, CLKSRC_LOW_OSC);
        chk(oscRun, 4'h1);
        chk(opMode, MODE_SINGLE);
        @(posedge mclk);
        modeSelectPin <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk(pinsModeSelect, 1'b1);
        chk(opMode, MODE_SINGLE);
        dec(32'h1000000, 13'h0);
        dec(32'h8000000, 13'h0);
        dec(32'hFF000000, 13'h0);
        dec(32'hFFC00000, 13'h0200);
        $display("reset test done");
    endtask : t_reset

    task t_protect;
        wr(2, 6'h33);
        chk({clkSrc, oscRun}, {CLKSRC_LOW_OSC, 4'h1});
        wr(0, 6'h1);
        wr(1, 6'h3);
        chk(externalBusEnable, 1'b0);
        wr(2, 6'h2F);
        chk({clkSrc, oscRun}, 6'h2F);
        wr(0, 6'h2);
        wr(2, 6'h11);
        chk({clkSrc, oscRun}, 6'h11);
        $display("protect test done");
    endtask : t_protect

    task t_ext;
        wr(1, 6'h3);
        chk(opMode, MODE_EXT_ROM);
        for (int i = 0; i < 15; i++) dec(at[i], ex[i]);
        wr(1, 6'h1);
        chk(opMode, MODE_EXT_NOROM);
        dec(32'hFF000000, 13'h0002);
        dec(32'hFFC00000, 13'h0002);
        wr(1, 6'h3);
        chk(onchipRomEnable, 1'b0);
        wr(1, 6'h0);
        chk(opMode, MODE_SINGLE);
        $display("extended test done");
    endtask : t_ext

    task t_boot;
        rst(1'b0, 1'b0);
        chk(opMode, MODE_BOOT_SCI);
        chk({writeProtectControl, onchipRomEnable}, 3'h1);
        chk(pinsUserBoot, 1'b0);
        rst(1'b0, 1'b1);
        chk(opMode, MODE_USER_BOOT);
        chk(pinsUserBoot, 1'b1);
        rst(1'b1, 1'b1);
        chk(opMode, MODE_SINGLE);
        $display("boot test done");
    endtask : t_boot

    initial begin
        failures = 0;
        samples_checked = 0;
        {reset_n, userBootPin, go, protWrite, sysWrite, clkWrite} = 6'h0;
        {romEnableIn, extBusEnableIn, protData, clkSrcIn, oscRunIn} = 10'h0;
        modeSelectPin = 1'b1;
        target = 32'h0;
        t_reset();
        t_protect();
        t_ext();
        t_boot();
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        give_verdict();
    end
endmodule : operating_mode_address_decode_tb_top
`default_nettype wire
